// *** logic/ucb_pkg.sv ***
package ucb_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_MODE = 16'hff70;
    localparam logic [15:0] ADDR_STATUS = 16'hff71;
    localparam logic [15:0] ADDR_BAUD = 16'hff73;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_TX_ENABLE = 7;
    localparam int MODE_RX_ENABLE = 6;
    localparam int MODE_PARITY_HI = 5;
    localparam int MODE_PARITY_LO = 4;
    localparam int MODE_CHAR_LEN = 3;
    localparam int MODE_STOP_BITS = 2;
    localparam int MODE_ERR_IRQ_MASK = 1;
    localparam int MODE_CLK_SRC = 0;
    localparam int STAT_PARITY_ERR = 2;
    localparam int STAT_FRAMING_ERR = 1;
    localparam int STAT_DATA_LOST = 0;
    localparam int BAUD_PRE_HI = 7;
    localparam int BAUD_PRE_LO = 4;
    localparam int BAUD_DIV_HI = 3;
    localparam int BAUD_DIV_LO = 0;

    // ------------------------------------------------------------------
    // Parity modes and baud counts
    // ------------------------------------------------------------------
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    localparam logic [3:0] PRE_CODE_LONG = 4'h0;
    localparam logic [3:0] PRE_EXP_LONG = 4'hb;
    localparam logic [3:0] PRE_CODE_FIRST = 4'h5;
    localparam logic [3:0] PRE_CODE_LAST = 4'he;
    localparam logic [3:0] PRE_CODE_OFFSET = 4'h4;
    localparam logic [3:0] PRE_EXP_NONE = 4'h0;
    localparam logic [5:0] DIV_BASE = 6'h10;
    localparam logic [3:0] DIV_CODE_UNDEF = 4'hf;

    function automatic logic [3:0] prescale_exp(input logic [3:0] code);
        if (code == PRE_CODE_LONG) begin
            return PRE_EXP_LONG;
        end else if (code >= PRE_CODE_FIRST && code <= PRE_CODE_LAST) begin
            return code - PRE_CODE_OFFSET;
        end
        return PRE_EXP_NONE;
    endfunction : prescale_exp

endpackage : ucb_pkg

// *** logic/ucb_baud_gen.sv ***
module ucb_baud_gen (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic osc_full_rate,
    input wire logic src_internal,
    input wire logic ext_clk_pin,
    input wire logic [3:0] prescale_sel,
    input wire logic [3:0] baud_divisor_sel,
    output logic tick_q
);

    logic half_q;
    logic ext_prev_q;
    logic [10:0] pre_cnt_q;
    logic [5:0] div_cnt_q;
    logic [3:0] pre_exp;
    logic [10:0] pre_mask;
    logic fxx_en;
    logic pre_tick;
    logic ext_rise;
    logic src_tick;
    logic div_ok;
    logic [5:0] limit;
    logic div_wrap;

    // Halved oscillator unless full rate is selected
    assign fxx_en = osc_full_rate | half_q;
    assign pre_exp = ucb_pkg::prescale_exp(prescale_sel);
    assign pre_mask = 11'((12'h1 << pre_exp) - 12'h1);
    // Prohibited codes give no source clock at all
    assign pre_tick = fxx_en && (pre_exp != ucb_pkg::PRE_EXP_NONE)
                      && ((pre_cnt_q & pre_mask) == pre_mask);
    assign ext_rise = ext_clk_pin & ~ext_prev_q;
    assign src_tick = src_internal ? pre_tick : ext_rise;
    assign div_ok = baud_divisor_sel != ucb_pkg::DIV_CODE_UNDEF;
    // Pin clock carries an extra divide by two
    assign limit = src_internal
                   ? ucb_pkg::DIV_BASE + 6'(baud_divisor_sel)
                   : 6'((ucb_pkg::DIV_BASE + 6'(baud_divisor_sel)) << 1);
    assign div_wrap = div_cnt_q == limit - 6'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
            ext_prev_q <= 1'b0;
            pre_cnt_q <= 11'h000;
            div_cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
            ext_prev_q <= ext_clk_pin;
            tick_q <= src_tick && div_ok && div_wrap && !restart;
            if (restart) begin
                pre_cnt_q <= 11'h000;
                div_cnt_q <= 6'h00;
            end else begin
                if (fxx_en) begin
                    pre_cnt_q <= pre_cnt_q + 11'h001;
                end
                if (src_tick) begin
                    div_cnt_q <= div_wrap ? 6'h00 : div_cnt_q + 6'h01;
                end
            end
        end
    end

endmodule : ucb_baud_gen

// *** logic/ucb_frame_eval.sv ***
module ucb_frame_eval (
    input wire logic [1:0] parity_mode,
    input wire logic char8,
    input wire logic [7:0] rx_data,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_bit,
    input wire logic [7:0] tx_data,
    output logic [7:0] rx_data_masked,
    output logic [7:0] tx_data_masked,
    output logic parity_err,
    output logic framing_err,
    output logic tx_parity_bit
);

    logic rx_ones_odd;

    // Seven-bit characters drop bit 7 on both directions
    assign rx_data_masked = {rx_data[7] & char8, rx_data[6:0]};
    assign tx_data_masked = {tx_data[7] & char8, tx_data[6:0]};
    assign rx_ones_odd = ^{rx_data_masked, rx_parity_bit};
    assign parity_err = (parity_mode == ucb_pkg::PAR_EVEN && rx_ones_odd)
                        || (parity_mode == ucb_pkg::PAR_ODD && !rx_ones_odd);
    // Only the first stop bit is looked at
    assign framing_err = !rx_stop_bit;
    assign tx_parity_bit = (parity_mode == ucb_pkg::PAR_EVEN)
                           ? ^tx_data_masked
                           : (parity_mode == ucb_pkg::PAR_ODD)
                           ? ~^tx_data_masked
                           : 1'b0;

endmodule : ucb_frame_eval

// *** logic/ucb_uart_ctrl.sv ***
// Contract
// - Mode register resets zero, bit or byte writable
// - Transmit enable bit gates the transmitter
// - Receive enable bit gates the receiver
// - Parity field selects none, odd, even
// - Zero parity sent, receive check skipped
// - Character length bit picks seven or eight
// - Stop length bit picks one or two
// - Receiver checks only the first stop bit
// - Error mask withholds completion event on error
// - Clock source bit picks pin or generator
// - Generator source releases external clock pin
// - Status register reads zero above bit two
// - Parity mismatch sets status bit two
// - Missing stop bit sets status bit one
// - Unread buffer at completion sets bit zero
// - Overrun repeats until receive buffer is read
// - Baud register resets zero, byte writes only
// - Prescaler code divides main clock by power
// - Oscillator halving select picks main clock
// - Divider code divides by k plus sixteen
// - Baud rate formula for both clock sources
// - Seven-bit mode ignores or clears bit seven
module ucb_uart_ctrl (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    // Register access
    input wire logic [15:0] ADDR_IN,
    input wire logic WR_STB_IN,
    input wire logic [7:0] WR_BITMASK_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic RD_STB_IN,
    output logic [7:0] RDATA_OUT,
    // Clock sources
    input wire logic OSC_HALVING_SEL_IN,
    input wire logic EXT_BAUD_CLK_PIN_IN,
    output logic EXT_BAUD_CLK_PIN_RELEASE_OUT,
    output logic BAUD_TICK_OUT,
    // Receive datapath
    input wire logic RX_FRAME_DONE_IN,
    input wire logic [7:0] RX_DATA_IN,
    input wire logic RX_PARITY_BIT_IN,
    input wire logic RX_STOP_BIT_IN,
    input wire logic RX_BUFFER_READ_IN,
    output logic RX_ENABLE_OUT,
    output logic [7:0] RX_BUFFER_REG_OUT,
    output logic RX_COMPLETE_OUT,
    // Transmit datapath
    input wire logic [7:0] TX_DATA_IN,
    output logic TX_ENABLE_OUT,
    output logic [7:0] TX_DATA_OUT,
    output logic TX_PARITY_EN_OUT,
    output logic TX_PARITY_BIT_OUT,
    output logic TX_TWO_STOP_OUT,
    output logic CHAR_8BIT_OUT
);

    // ------------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] baud_q;
    logic [2:0] status_q;
    logic [2:0] status_d;
    logic rx_unread_q;
    logic [7:0] rdata_d;
    logic tick_w;
    logic sel_mode;
    logic sel_status;
    logic sel_baud;
    logic wr_mode;
    logic wr_baud;
    logic tx_enable;
    logic rx_enable;
    logic [1:0] parity_mode;
    logic char_len_sel;
    logic stop_bits_sel;
    logic rx_err_irq_mask;
    logic clk_src_internal;
    logic rx_done;
    logic any_err;
    logic parity_err;
    logic framing_err;
    logic data_lost;
    logic [7:0] rx_data_masked;
    logic [7:0] tx_data_masked;
    logic tx_parity_bit;
    logic complete_d;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign sel_mode = ADDR_IN == ucb_pkg::ADDR_MODE;
    assign sel_status = ADDR_IN == ucb_pkg::ADDR_STATUS;
    assign sel_baud = ADDR_IN == ucb_pkg::ADDR_BAUD;
    assign wr_mode = WR_STB_IN && sel_mode;
    assign wr_baud = WR_STB_IN && sel_baud;

    // ------------------------------------------------------------------
    // Mode fields
    // ------------------------------------------------------------------
    assign tx_enable = mode_q[ucb_pkg::MODE_TX_ENABLE];
    assign rx_enable = mode_q[ucb_pkg::MODE_RX_ENABLE];
    assign parity_mode = {mode_q[ucb_pkg::MODE_PARITY_HI],
                          mode_q[ucb_pkg::MODE_PARITY_LO]};
    assign char_len_sel = mode_q[ucb_pkg::MODE_CHAR_LEN];
    assign stop_bits_sel = mode_q[ucb_pkg::MODE_STOP_BITS];
    assign rx_err_irq_mask = mode_q[ucb_pkg::MODE_ERR_IRQ_MASK];
    assign clk_src_internal = mode_q[ucb_pkg::MODE_CLK_SRC];

    // Bit-enable write lets single-bit set/clear leave neighbours alone
    assign mode_d = (mode_q & ~WR_BITMASK_IN)
                    | (WDATA_IN & WR_BITMASK_IN);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mode_q <= ucb_pkg::MODE_RESET;
            baud_q <= ucb_pkg::BAUD_RESET;
        end else begin
            if (wr_mode) begin
                mode_q <= mode_d;
            end
            // Byte-wide only; mask is ignored here
            if (wr_baud) begin
                baud_q <= WDATA_IN;
            end
        end
    end

    // ------------------------------------------------------------------
    // Baud generation
    // ------------------------------------------------------------------
    // A baud write restarts the counters; a write mid-frame still
    // corrupts that frame, so software must avoid it.
    ucb_baud_gen u_baud (
        .clk(SYS_CLK_IN),
        .rst_n(RST_B_IN),
        .restart(wr_baud),
        .osc_full_rate(OSC_HALVING_SEL_IN),
        .src_internal(clk_src_internal),
        .ext_clk_pin(EXT_BAUD_CLK_PIN_IN),
        .prescale_sel(baud_q[ucb_pkg::BAUD_PRE_HI:ucb_pkg::BAUD_PRE_LO]),
        .baud_divisor_sel(baud_q[ucb_pkg::BAUD_DIV_HI:ucb_pkg::BAUD_DIV_LO]),
        .tick_q(tick_w)
    );

    // ------------------------------------------------------------------
    // Frame evaluation
    // ------------------------------------------------------------------
    ucb_frame_eval u_eval (
        .parity_mode(parity_mode),
        .char8(char_len_sel),
        .rx_data(RX_DATA_IN),
        .rx_parity_bit(RX_PARITY_BIT_IN),
        .rx_stop_bit(RX_STOP_BIT_IN),
        .tx_data(TX_DATA_IN),
        .rx_data_masked(rx_data_masked),
        .tx_data_masked(tx_data_masked),
        .parity_err(parity_err),
        .framing_err(framing_err),
        .tx_parity_bit(tx_parity_bit)
    );

    // ------------------------------------------------------------------
    // Receive status
    // ------------------------------------------------------------------
    // Frames finishing while the receiver is stopped are dropped
    assign rx_done = RX_FRAME_DONE_IN && rx_enable;
    // Overrun keeps firing while the old byte stays unread
    assign data_lost = rx_unread_q && !RX_BUFFER_READ_IN;
    assign status_d = {parity_err, framing_err, data_lost};
    assign any_err = parity_err || framing_err || data_lost;
    assign complete_d = rx_done
                        && !(any_err && rx_err_irq_mask);

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            status_q <= ucb_pkg::STATUS_RESET[2:0];
            rx_unread_q <= 1'b0;
            RX_BUFFER_REG_OUT <= 8'h00;
            RX_COMPLETE_OUT <= 1'b0;
        end else begin
            RX_COMPLETE_OUT <= complete_d;
            if (rx_done) begin
                status_q <= status_d;
                RX_BUFFER_REG_OUT <= rx_data_masked;
                rx_unread_q <= 1'b1;
            end else if (RX_BUFFER_READ_IN) begin
                rx_unread_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    assign rdata_d = !RD_STB_IN ? RDATA_OUT
                   : sel_mode ? mode_q
                   : sel_status ? {5'h00, status_q}
                   : sel_baud ? baud_q
                   : ucb_pkg::READ_UNMAPPED;

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            RDATA_OUT <= 8'h00;
        end else begin
            RDATA_OUT <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Datapath controls
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            TX_ENABLE_OUT <= 1'b0;
            RX_ENABLE_OUT <= 1'b0;
            TX_DATA_OUT <= 8'h00;
            TX_PARITY_EN_OUT <= 1'b0;
            TX_PARITY_BIT_OUT <= 1'b0;
            TX_TWO_STOP_OUT <= 1'b0;
            CHAR_8BIT_OUT <= 1'b0;
            BAUD_TICK_OUT <= 1'b0;
            EXT_BAUD_CLK_PIN_RELEASE_OUT <= 1'b0;
        end else begin
            TX_ENABLE_OUT <= tx_enable;
            RX_ENABLE_OUT <= rx_enable;
            TX_DATA_OUT <= tx_data_masked;
            TX_PARITY_EN_OUT <= parity_mode != ucb_pkg::PAR_NONE;
            TX_PARITY_BIT_OUT <= tx_parity_bit;
            TX_TWO_STOP_OUT <= stop_bits_sel;
            CHAR_8BIT_OUT <= char_len_sel;
            // No ticks while both directions are stopped
            BAUD_TICK_OUT <= tick_w && (tx_enable || rx_enable);
            EXT_BAUD_CLK_PIN_RELEASE_OUT <= clk_src_internal;
        end
    end

endmodule : ucb_uart_ctrl

// *** sim/ucb_uart_ctrl_asserts.sv ***
module ucb_uart_ctrl_asserts (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    // Register access
    input wire logic [15:0] ADDR_IN,
    input wire logic WR_STB_IN,
    input wire logic [7:0] WR_BITMASK_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic RD_STB_IN,
    input wire logic [7:0] RDATA_OUT,
    // Clock sources
    input wire logic EXT_BAUD_CLK_PIN_RELEASE_OUT,
    input wire logic BAUD_TICK_OUT,
    // Receive datapath
    input wire logic RX_FRAME_DONE_IN,
    input wire logic [7:0] RX_DATA_IN,
    input wire logic RX_ENABLE_OUT,
    input wire logic [7:0] RX_BUFFER_REG_OUT,
    input wire logic RX_COMPLETE_OUT,
    // Transmit datapath
    input wire logic [7:0] TX_DATA_IN,
    input wire logic TX_ENABLE_OUT,
    input wire logic [7:0] TX_DATA_OUT,
    input wire logic TX_PARITY_EN_OUT,
    input wire logic TX_PARITY_BIT_OUT,
    input wire logic CHAR_8BIT_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    wire mode_sel = WR_STB_IN && ADDR_IN == ucb_pkg::ADDR_MODE;
    wire unmapped = ADDR_IN != ucb_pkg::ADDR_MODE &&
        ADDR_IN != ucb_pkg::ADDR_STATUS && ADDR_IN != ucb_pkg::ADDR_BAUD;

    // A frame is taken only while the receiver was enabled
    sequence rx_taken;
        RX_FRAME_DONE_IN ##1 RX_ENABLE_OUT;
    endsequence
    sequence rx_dropped;
        RX_FRAME_DONE_IN ##1 !RX_ENABLE_OUT;
    endsequence

    AST_RD_UNMAPPED: assert property (RD_STB_IN && unmapped
        |=> RDATA_OUT == ucb_pkg::READ_UNMAPPED) else $error("unmapped read");
    AST_STATUS_UPPER: assert property (
        RD_STB_IN && ADDR_IN == ucb_pkg::ADDR_STATUS |=> RDATA_OUT[7:3] == 5'h00)
        else $error("status upper bits set");
    AST_RDATA_HOLD: assert property (!RD_STB_IN |=> $stable(RDATA_OUT))
        else $error("read data moved without a read");
    AST_TX_ENABLE: assert property (
        mode_sel && WR_BITMASK_IN[7] |-> ##2 TX_ENABLE_OUT == $past(WDATA_IN[7], 2))
        else $error("transmit enable not taken from write");
    AST_PIN_RELEASE: assert property (
        mode_sel && WR_BITMASK_IN[0] |-> ##2
        EXT_BAUD_CLK_PIN_RELEASE_OUT == $past(WDATA_IN[0], 2))
        else $error("pin release not taken from write");
    AST_RX_OFF: assert property (rx_dropped |-> !RX_COMPLETE_OUT)
        else $error("completion while receiver stopped");
    AST_RX_BUFFER: assert property (rx_taken |-> RX_BUFFER_REG_OUT ==
        {CHAR_8BIT_OUT & $past(RX_DATA_IN[7]), $past(RX_DATA_IN[6:0])})
        else $error("receive buffer mismatch");
    AST_CPL_CAUSE: assert property (
        RX_COMPLETE_OUT |-> $past(RX_FRAME_DONE_IN))
        else $error("completion without a frame");
    AST_TX_MASK: assert property ($past(RST_B_IN) |-> TX_DATA_OUT ==
        {CHAR_8BIT_OUT & $past(TX_DATA_IN[7]), $past(TX_DATA_IN[6:0])})
        else $error("transmit data mismatch");
    AST_NO_PARITY: assert property (
        !TX_PARITY_EN_OUT |-> !TX_PARITY_BIT_OUT) else $error("stray parity bit");
    AST_TICK_OFF: assert property (
        (!TX_ENABLE_OUT && !RX_ENABLE_OUT) [*3] |-> !BAUD_TICK_OUT)
        else $error("tick while channel stopped");
    AST_TICK_PULSE: assert property (
        BAUD_TICK_OUT |=> !BAUD_TICK_OUT [*8]) else $error("ticks too close");
endmodule : ucb_uart_ctrl_asserts

bind ucb_uart_ctrl ucb_uart_ctrl_asserts ucb_uart_ctrl_asserts_inst (
    .SYS_CLK_IN, .RST_B_IN, .ADDR_IN, .WR_STB_IN, .WR_BITMASK_IN, .WDATA_IN,
    .RD_STB_IN, .RDATA_OUT, .EXT_BAUD_CLK_PIN_RELEASE_OUT, .BAUD_TICK_OUT,
    .RX_FRAME_DONE_IN, .RX_DATA_IN, .RX_ENABLE_OUT, .RX_BUFFER_REG_OUT,
    .RX_COMPLETE_OUT, .TX_DATA_IN, .TX_ENABLE_OUT, .TX_DATA_OUT,
    .TX_PARITY_EN_OUT, .TX_PARITY_BIT_OUT, .CHAR_8BIT_OUT);

// *** sim/ucb_far_end.sv ***
module ucb_far_end (
    // Clock and pin control
    input wire logic clk_in,
    input wire logic ext_run_in,
    // Frame results
    output logic done_out,
    output logic [7:0] data_out,
    output logic par_out,
    output logic stop_out,
    // External baud clock
    output logic ext_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        done_out = 1'b0;
        data_out = 8'h00;
        par_out = 1'b0;
        stop_out = 1'b0;
        ext_pin_out = 1'b0;
    end

    // Pin clock stands still unless asked to run
    always @(negedge clk_in) begin
        ext_pin_out <= ext_run_in ? ~ext_pin_out : 1'b0;
    end

    // Only the first stop bit level is handed over
    task automatic send(input logic [7:0] d, input logic p, input logic s);
        @(negedge clk_in);
        done_out = 1'b1;
        data_out = d;
        par_out = p;
        stop_out = s;
        @(negedge clk_in);
        done_out = 1'b0;
        data_out = ~d;
        par_out = ~p;
        stop_out = ~s;
    endtask : send
endmodule : ucb_far_end

// *** sim/ucb_uart_ctrl_tb.sv ***
module ucb_uart_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst_b, wr, rd, osc, rx_rd, ext_run;
    logic [15:0] addr;
    logic [7:0] mask, wdata, tx_d, rdata, rx_buffer_reg, txo, rx_d;
    logic done, par, stop, pin, rel, tick, rxen, cpl, txen, pen, pbit, two, c8;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int n_cpl = 0;

    ucb_uart_ctrl ucb_uart_ctrl_inst (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
        .ADDR_IN(addr), .WR_STB_IN(wr), .WR_BITMASK_IN(mask), .WDATA_IN(wdata),
        .RD_STB_IN(rd), .RDATA_OUT(rdata), .OSC_HALVING_SEL_IN(osc),
        .EXT_BAUD_CLK_PIN_IN(pin), .EXT_BAUD_CLK_PIN_RELEASE_OUT(rel),
        .BAUD_TICK_OUT(tick), .RX_FRAME_DONE_IN(done), .RX_DATA_IN(rx_d),
        .RX_PARITY_BIT_IN(par), .RX_STOP_BIT_IN(stop), .RX_BUFFER_READ_IN(rx_rd),
        .RX_ENABLE_OUT(rxen), .RX_BUFFER_REG_OUT(rx_buffer_reg), .RX_COMPLETE_OUT(cpl),
        .TX_DATA_IN(tx_d), .TX_ENABLE_OUT(txen), .TX_DATA_OUT(txo),
        .TX_PARITY_EN_OUT(pen), .TX_PARITY_BIT_OUT(pbit),
        .TX_TWO_STOP_OUT(two), .CHAR_8BIT_OUT(c8));

    ucb_far_end ucb_far_end_inst (.clk_in(clk), .ext_run_in(ext_run),
        .done_out(done), .data_out(rx_d), .par_out(par), .stop_out(stop),
        .ext_pin_out(pin));

    // ------------------------------------------------------------------
    // Clock, watchdog and tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counted on the falling edge, where the completion pulse has settled
    always @(negedge clk) begin
        cyc++;
        if (cpl === 1'b1) n_cpl++;
        if (cyc == 30000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [15:0] exp, got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, m);
        @(negedge clk);
        addr = a;
        wdata = d;
        mask = m;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk("read data", {8'h00, exp}, {8'h00, rdata});
    endtask : rd_reg

    // Mode changes always go through a stopped channel first
    task automatic set_mode(input logic [7:0] m);
        wr_reg(16'hff70, m & 8'h3f, 8'hff);
        wr_reg(16'hff70, m, 8'hff);
    endtask : set_mode

    task automatic frame(input logic [7:0] d, input logic p, s, rd_after);
        ucb_far_end_inst.send(d, p, s);
        if (rd_after) begin
            rx_rd = 1'b1;
            @(negedge clk);
            rx_rd = 1'b0;
        end
    endtask : frame

    task automatic period(input logic [15:0] exp);
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        n = 1;
        while (tick !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("tick period", exp, n[15:0]);
    endtask : period

    task automatic quiet;
        int t;
        t = 0;
        repeat (3) @(negedge clk);
        repeat (300) begin
            @(negedge clk);
            if (tick === 1'b1) t++;
        end
        chk("tick count", 16'h0000, t[15:0]);
    endtask : quiet

    // Baud register is only written while the channel is stopped
    task automatic baud(input logic [7:0] m, c, input logic [15:0] exp);
        wr_reg(16'hff70, m & 8'h3f, 8'hff);
        wr_reg(16'hff73, c, 8'hff);
        wr_reg(16'hff70, m, 8'hff);
        if (exp == 16'h0000)
            quiet();
        else
            period(exp);
    endtask : baud

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        {wr, rd, osc, rx_rd, ext_run} = 5'h04;
        addr = 16'h0000;
        {mask, wdata, tx_d} = 24'h000000;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        rd_reg(16'hff70, 8'h00);
        rd_reg(16'hff71, 8'h00);
        rd_reg(16'hff73, 8'h00);
        rd_reg(16'hff72, 8'h00);
        wr_reg(16'hff71, 8'hff, 8'hff);
        rd_reg(16'hff71, 8'h00);
        tx_d = 8'h07;
        for (int p = 0; p < 4; p++) begin
            set_mode({2'b11, p[1:0], 4'b1000});
            frame(8'h55, 1'b1, 1'b1, 1'b1);
            rd_reg(16'hff71, {5'h00, p == 3, 2'b00});
            chk("parity bit", {15'h0, p == 3}, {15'h0, pbit});
            chk("parity on", {15'h0, p != 0}, {15'h0, pen});
        end
        chk("completions", 16'h0004, n_cpl[15:0]);
        set_mode(8'h0a);
        wr_reg(16'hff70, 8'hff, 8'h40);
        rd_reg(16'hff70, 8'h4a);
        chk("rx enable", 16'h0001, {15'h0, rxen});
        frame(8'ha5, 1'b0, 1'b0, 1'b1);
        rd_reg(16'hff71, 8'h02);
        chk("rx buffer", 16'h00a5, {8'h00, rx_buffer_reg});
        chk("completions", 16'h0004, n_cpl[15:0]);
        frame(8'h11, 1'b0, 1'b1, 1'b0);
        rd_reg(16'hff71, 8'h00);
        frame(8'h22, 1'b0, 1'b1, 1'b0);
        rd_reg(16'hff71, 8'h01);
        frame(8'h33, 1'b0, 1'b1, 1'b1);
        rd_reg(16'hff71, 8'h01);
        frame(8'h44, 1'b0, 1'b1, 1'b0);
        rd_reg(16'hff71, 8'h00);
        chk("completions", 16'h0006, n_cpl[15:0]);
        chk("rx buffer", 16'h0044, {8'h00, rx_buffer_reg});
        tx_d = 8'hff;
        set_mode(8'hc4);
        frame(8'hff, 1'b0, 1'b1, 1'b1);
        chk("rx buffer", 16'h007f, {8'h00, rx_buffer_reg});
        chk("tx data", 16'h007f, {8'h00, txo});
        chk("two stop", 16'h0001, {15'h0, two});
        chk("eight bit", 16'h0000, {15'h0, c8});
        set_mode(8'h00);
        frame(8'h5a, 1'b0, 1'b0, 1'b1);
        chk("completions", 16'h0007, n_cpl[15:0]);
        // Dropped frame leaves the overrun of the 7-bit frame standing
        rd_reg(16'hff71, 8'h01);
        baud(8'h81, 8'h50, 16'h0020);
        rd_reg(16'hff73, 8'h50);
        chk("pin release", 16'h0001, {15'h0, rel});
        chk("tx enable", 16'h0001, {15'h0, txen});
        baud(8'h81, 8'h5e, 16'h003c);
        osc = 1'b0;
        baud(8'h81, 8'h50, 16'h0040);
        baud(8'h81, 8'h61, 16'h0088);
        baud(8'h81, 8'h10, 16'h0000);
        baud(8'h81, 8'h5f, 16'h0000);
        ext_run = 1'b1;
        baud(8'h80, 8'h50, 16'h0040);
        chk("pin release", 16'h0000, {15'h0, rel});
        baud(8'h40, 8'h52, 16'h0048);
        wr_reg(16'hff70, 8'h00, 8'hff);
        quiet();
        complete_run();
    end
endmodule : ucb_uart_ctrl_tb
